// File: hw/hmec_top.sv
// headlight mode, lighting effect and speed curve control
`timescale 1ns/1ps
module hmec_top
    import hmec_pkg::*;
#(
    parameter int TICK_CYC = PHASE_TICK_CYC
)
(
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic CV_WR,
    input wire logic CV_RD,
    input wire logic [9:0] CV_NUM,
    input wire logic [7:0] CV_WDATA,
    input wire logic FACTORY_RST,
    input wire logic [4:0] SPEED_STEP,
    input wire logic DIR_FWD,
    input wire logic LIGHT_KEY,
    output logic [7:0] CV_RDATA,
    output logic CV_RACK,
    output logic FRONT_LIGHT,
    output logic REAR_LIGHT,
    output logic [7:0] MOTOR_LEVEL
);
    import hmec_pkg::*;

    // ***************************************************
    // reset release
    // ***************************************************
    logic rst_s1_r;
    logic rst_n;

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!rst_n);

    // ***************************************************
    // configuration variables
    // ***************************************************
    logic [7:0] period_r, period_nxt, mode_r, mode_nxt, front_r, front_nxt, rear_r, rear_nxt;
    logic [7:0] start_r, start_nxt, mid_r, mid_nxt, top_r, top_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rack_r, rack_nxt;
    logic en_r, en_nxt;

    always_comb
    begin
        period_nxt = period_r;
        mode_nxt = mode_r;
        front_nxt = front_r;
        rear_nxt = rear_r;
        start_nxt = start_r;
        mid_nxt = mid_r;
        top_nxt = top_r;
        en_nxt = en_r ^ LIGHT_KEY;
        if (FACTORY_RST)
        begin
            period_nxt = RST_PERIOD;
            mode_nxt = RST_MODE;
            front_nxt = RST_FRONT;
            rear_nxt = RST_REAR;
            start_nxt = RST_START;
            mid_nxt = RST_MID;
            top_nxt = RST_TOP;
        end
        else if (CV_WR)
        begin
            unique case (CV_NUM)
                CV_PERIOD: period_nxt = (CV_WDATA == 8'h00) ? PERIOD_MIN : CV_WDATA;
                CV_MODE: mode_nxt = CV_WDATA;
                CV_FRONT: front_nxt = CV_WDATA;
                CV_REAR: rear_nxt = CV_WDATA;
                CV_START: start_nxt = CV_WDATA;
                CV_MID: mid_nxt = CV_WDATA;
                CV_TOP: top_nxt = CV_WDATA;
                default: ;
            endcase
        end
        rack_nxt = CV_RD;
        unique case (CV_NUM)
            CV_PERIOD: rdata_nxt = period_r;
            CV_MODE: rdata_nxt = mode_r;
            CV_FRONT: rdata_nxt = front_r;
            CV_REAR: rdata_nxt = rear_r;
            CV_START: rdata_nxt = start_r;
            CV_MID: rdata_nxt = mid_r;
            CV_TOP: rdata_nxt = top_r;
            default: rdata_nxt = 8'h00;
        endcase
        if (!CV_RD)
        begin
            rdata_nxt = rdata_r;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            period_r <= RST_PERIOD;
            mode_r <= RST_MODE;
            front_r <= RST_FRONT;
            rear_r <= RST_REAR;
            start_r <= RST_START;
            mid_r <= RST_MID;
            top_r <= RST_TOP;
            rdata_r <= 8'h00;
            rack_r <= 1'b0;
            en_r <= 1'b0;
        end
        else
        begin
            period_r <= period_nxt;
            mode_r <= mode_nxt;
            front_r <= front_nxt;
            rear_r <= rear_nxt;
            start_r <= start_nxt;
            mid_r <= mid_nxt;
            top_r <= top_nxt;
            rdata_r <= rdata_nxt;
            rack_r <= rack_nxt;
            en_r <= en_nxt;
        end
    end

    // ***************************************************
    // pattern phase and random source
    // ***************************************************
    logic [31:0] pre_r, pre_nxt;
    logic [3:0] sub_r, sub_nxt, phase_r, phase_nxt;
    logic [7:0] pwm_r, pwm_nxt;
    logic [15:0] lfsr_r, lfsr_nxt;

    always_comb
    begin
        pre_nxt = pre_r + 32'h0000_0001;
        sub_nxt = sub_r;
        phase_nxt = phase_r;
        if (pre_r >= 32'(TICK_CYC - 1))
        begin
            pre_nxt = 32'h0000_0000;
            sub_nxt = sub_r + 4'h1;
            if (sub_r >= period_r[3:0] - 4'h1)
            begin
                sub_nxt = 4'h0;
                phase_nxt = phase_r + 4'h1;
            end
        end
        pwm_nxt = pwm_r + 8'h01;
        lfsr_nxt = (pwm_r == 8'hFF) ? {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]} : lfsr_r;
    end

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_r <= 32'h0000_0000;
            sub_r <= 4'h0;
            phase_r <= 4'h0;
            pwm_r <= 8'h00;
            lfsr_r <= 16'hACE1;
        end
        else
        begin
            pre_r <= pre_nxt;
            sub_r <= sub_nxt;
            phase_r <= phase_nxt;
            pwm_r <= pwm_nxt;
            lfsr_r <= lfsr_nxt;
        end
    end

    // ***************************************************
    // effect shapes and mode decode
    // ***************************************************
    function automatic logic [7:0] eff_duty(input logic [3:0] sel, input logic [3:0] ph, input logic [7:0] rnd);
        logic [7:0] tri_lvl;
        tri_lvl = {(ph[3] ? ~ph[2:0] : ph[2:0]), 5'h1F};
        unique case (hmec_effect_e'(sel))
            HMEC_EFF_OFF, HMEC_EFF_RSVD: eff_duty = DUTY_OFF;
            HMEC_EFF_DIM6: eff_duty = DUTY_6;
            HMEC_EFF_DIM25: eff_duty = DUTY_25;
            HMEC_EFF_DIM50: eff_duty = DUTY_50;
            HMEC_EFF_ON: eff_duty = DUTY_FULL;
            HMEC_EFF_FLICKER: eff_duty = rnd | DUTY_25;
            HMEC_EFF_STRATO: eff_duty = ph[3] ? DUTY_25 : DUTY_FULL;
            HMEC_EFF_OSC, HMEC_EFF_GYRA: eff_duty = tri_lvl;
            HMEC_EFF_MARS: eff_duty = tri_lvl | DUTY_25;
            HMEC_EFF_MARKER: eff_duty = (ph[3:1] == 3'h0) ? DUTY_FULL : DUTY_OFF;
            HMEC_EFF_DOME1, HMEC_EFF_DOME2: eff_duty = (ph[3:2] == 2'h0) ? DUTY_FULL : DUTY_6;
            HMEC_EFF_STROBE1: eff_duty = (ph == 4'h0) ? DUTY_FULL : DUTY_OFF;
            HMEC_EFF_STROBE2: eff_duty = (ph == 4'h0 || ph == 4'h2) ? DUTY_FULL : DUTY_OFF;
        endcase
    endfunction : eff_duty

    // returns {auto-dim, rear lit, front lit}
    function automatic logic [2:0] mode_decode(input logic [3:0] m, input logic fwd);
        unique case (m)
            HMEC_MODE_DIR: mode_decode = {1'b0, ~fwd, fwd};
            HMEC_MODE_DIR_DIM: mode_decode = {1'b1, ~fwd, fwd};
            HMEC_MODE_FRONT: mode_decode = 3'b001;
            HMEC_MODE_FRONT_DIM: mode_decode = 3'b101;
            HMEC_MODE_REAR: mode_decode = 3'b010;
            HMEC_MODE_REAR_DIM: mode_decode = 3'b110;
            HMEC_MODE_BOTH: mode_decode = 3'b011;
            HMEC_MODE_BOTH_DIM: mode_decode = 3'b111;
            HMEC_MODE_INV: mode_decode = {1'b0, fwd, ~fwd};
            HMEC_MODE_INV_DIM: mode_decode = {1'b1, fwd, ~fwd};
            default: mode_decode = {1'b0, ~fwd, fwd};
        endcase
    endfunction : mode_decode

    // ***************************************************
    // headlight drivers
    // ***************************************************
    logic [2:0] dec;
    logic dimmed;
    logic [7:0] duty [2];
    logic [1:0] light_r, light_nxt;

    always_comb
    begin
        dec = mode_decode(mode_r[3:0], DIR_FWD);
        dimmed = dec[2] && (SPEED_STEP == 5'h00);
        for (int i = 0; i < 2; i++)
        begin
            if (!en_r || !dec[i])
            begin
                duty[i] = DUTY_OFF;
            end
            else if (dimmed)
            begin
                duty[i] = DUTY_AUTO_DIM;
            end
            else
            begin
                duty[i] = eff_duty((i == 0) ? front_r[3:0] : rear_r[3:0], phase_r, lfsr_r[7:0]);
            end
            light_nxt[i] = (duty[i] == DUTY_FULL) || (pwm_r < duty[i]);
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            light_r <= 2'b00;
        end
        else
        begin
            light_r <= light_nxt;
        end
    end

    hmec_speed_curve u_curve (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .step(SPEED_STEP),
        .start_lvl(start_r),
        .mid_lvl(mid_r),
        .top_lvl(top_r),
        .level(MOTOR_LEVEL)
    );

    assign FRONT_LIGHT = light_r[0];
    assign REAR_LIGHT = light_r[1];
    assign CV_RDATA = rdata_r;
    assign CV_RACK = rack_r;

    // ***************************************************
    // checks
    // ***************************************************
    auto_dim_a: assert property (en_r && mode_r == 8'h01 && DIR_FWD && SPEED_STEP == 5'h00 |-> duty[0] == DUTY_AUTO_DIM)
        else $error("headlight not dimmed at zero speed");
    dim_steady_a: assert property (dimmed && en_r && dec[0] && $stable(dimmed) |-> $stable(duty[0]))
        else $error("effect visible while dimmed");
    resume_a: assert property (en_r && mode_r == 8'h01 && DIR_FWD && front_r == 8'h04 && SPEED_STEP != 5'h00
        |=> FRONT_LIGHT)
        else $error("headlight not restored above zero speed");
    front_always_a: assert property (en_r && mode_r == 8'h02 && front_r == 8'h04 |=> FRONT_LIGHT && !REAR_LIGHT)
        else $error("front headlight not held on");
    rear_always_a: assert property (en_r && mode_r == 8'h05 && rear_r == 8'h04 && SPEED_STEP != 5'h00
        |=> REAR_LIGHT && !FRONT_LIGHT)
        else $error("rear headlight not held on");
    both_on_a: assert property (mode_r == 8'h06 |-> dec == 3'b011)
        else $error("both headlights not selected");
    inverted_map_a: assert property (mode_r == 8'h08 && DIR_FWD |-> dec == 3'b010)
        else $error("inverted mapping wrong");
    reserved_mode_a: assert property (mode_r[3:0] >= 4'hA |-> dec == {1'b0, ~DIR_FWD, DIR_FWD})
        else $error("reserved mode not directional");
    zero_period_a: assert property (CV_WR && !FACTORY_RST && CV_NUM == CV_PERIOD && CV_WDATA == 8'h00
        |=> period_r == PERIOD_MIN)
        else $error("zero period not replaced by one");
    factory_a: assert property (FACTORY_RST |=> mode_r == RST_MODE && period_r == RST_PERIOD
        && front_r == RST_FRONT && top_r == RST_TOP)
        else $error("factory values not restored");
    toggle_a: assert property (LIGHT_KEY |=> en_r != $past(en_r))
        else $error("light enable did not toggle");
    dark_a: assert property (!en_r ##1 !en_r |=> !FRONT_LIGHT && !REAR_LIGHT)
        else $error("light on while disabled");
    mid_anchor_a: assert property (SPEED_STEP == STEP_MID && CV_NUM != CV_MID |=> MOTOR_LEVEL == $past(mid_r))
        else $error("mid anchor not at step 14");
endmodule : hmec_top

// File: common/hmec_pkg.sv
// constants shared by the headlight mode and effect control block
package hmec_pkg;
    // configuration variable numbers
    localparam logic [9:0] CV_START = 10'h002;
    localparam logic [9:0] CV_TOP = 10'h005;
    localparam logic [9:0] CV_MID = 10'h006;
    localparam logic [9:0] CV_PERIOD = 10'h03B;
    localparam logic [9:0] CV_MODE = 10'h03C;
    localparam logic [9:0] CV_FRONT = 10'h03D;
    localparam logic [9:0] CV_REAR = 10'h03E;
    // factory values
    localparam logic [7:0] RST_PERIOD = 8'h03;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_FRONT = 8'h04;
    localparam logic [7:0] RST_REAR = 8'h04;
    localparam logic [7:0] RST_START = 8'h00;
    localparam logic [7:0] RST_MID = 8'h80;
    localparam logic [7:0] RST_TOP = 8'hFF;
    localparam logic [7:0] PERIOD_MIN = 8'h01;
    // timing
    localparam int CLK_MHZ = 100;
    localparam int HALF_SECOND_MS = 500;
    localparam int HALF_SECOND_CYC = HALF_SECOND_MS * 1000 * CLK_MHZ;
    localparam int PHASE_STEPS = 16;
    localparam int PHASE_TICK_CYC = HALF_SECOND_CYC / PHASE_STEPS;
    // brightness duties
    localparam logic [7:0] DUTY_OFF = 8'h00;
    localparam logic [7:0] DUTY_6 = 8'h0F;
    localparam logic [7:0] DUTY_25 = 8'h40;
    localparam logic [7:0] DUTY_50 = 8'h80;
    localparam logic [7:0] DUTY_FULL = 8'hFF;
    localparam logic [7:0] DUTY_AUTO_DIM = 8'h20;
    // speed curve anchors
    localparam logic [4:0] STEP_LOW = 5'h01;
    localparam logic [4:0] STEP_MID = 5'h0E;
    localparam logic [4:0] STEP_TOP = 5'h1C;
    // lighting effect selections
    typedef enum logic [3:0] {
        HMEC_EFF_OFF = 4'h0, HMEC_EFF_DIM6 = 4'h1, HMEC_EFF_DIM25 = 4'h2, HMEC_EFF_DIM50 = 4'h3,
        HMEC_EFF_ON = 4'h4, HMEC_EFF_STRATO = 4'h5, HMEC_EFF_OSC = 4'h6, HMEC_EFF_MARKER = 4'h7,
        HMEC_EFF_DOME1 = 4'h8, HMEC_EFF_GYRA = 4'h9, HMEC_EFF_MARS = 4'hA, HMEC_EFF_DOME2 = 4'hB,
        HMEC_EFF_STROBE1 = 4'hC, HMEC_EFF_STROBE2 = 4'hD, HMEC_EFF_RSVD = 4'hE, HMEC_EFF_FLICKER = 4'hF
    } hmec_effect_e;
    // headlight modes
    typedef enum logic [3:0] {
        HMEC_MODE_DIR = 4'h0, HMEC_MODE_DIR_DIM = 4'h1, HMEC_MODE_FRONT = 4'h2, HMEC_MODE_FRONT_DIM = 4'h3,
        HMEC_MODE_REAR = 4'h4, HMEC_MODE_REAR_DIM = 4'h5, HMEC_MODE_BOTH = 4'h6, HMEC_MODE_BOTH_DIM = 4'h7,
        HMEC_MODE_INV = 4'h8, HMEC_MODE_INV_DIM = 4'h9
    } hmec_mode_e;
endpackage : hmec_pkg

// File: hw/hmec_speed_curve.sv
// three-point speed curve: start, mid and top anchors with interpolation
`timescale 1ns/1ps
module hmec_speed_curve
    import hmec_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] step,
    input wire logic [7:0] start_lvl,
    input wire logic [7:0] mid_lvl,
    input wire logic [7:0] top_lvl,
    output logic [7:0] level
);
    logic [7:0] level_r;
    logic [7:0] level_nxt;
    logic signed [15:0] diff;
    logic signed [15:0] span;
    logic signed [15:0] acc;

    always_comb
    begin
        diff = 16'sh0000;
        span = 16'sh0000;
        acc = 16'sh0000;
        if (step == 5'h00)
        begin
            level_nxt = 8'h00;
        end
        else if (step <= STEP_MID)
        begin
            diff = $signed({8'h00, mid_lvl}) - $signed({8'h00, start_lvl});
            span = $signed({11'h000, step - STEP_LOW});
            acc = $signed({8'h00, start_lvl}) + (diff * span) / 16'sd13;
            level_nxt = acc[7:0];
        end
        else if (step < STEP_TOP)
        begin
            diff = $signed({8'h00, top_lvl}) - $signed({8'h00, mid_lvl});
            span = $signed({11'h000, step - STEP_MID});
            acc = $signed({8'h00, mid_lvl}) + (diff * span) / 16'sd14;
            level_nxt = acc[7:0];
        end
        else
        begin
            level_nxt = top_lvl;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            level_r <= 8'h00;
        end
        else
        begin
            level_r <= level_nxt;
        end
    end

    assign level = level_r;
endmodule : hmec_speed_curve

// File: sim/hmec_station.sv
// command station and throttle model driving the headlight control block
`timescale 1ns/1ps
module hmec_station
(
    input wire logic clk,
    input wire logic rack,
    input wire logic [7:0] rdata,
    output logic cv_wr,
    output logic cv_rd,
    output logic [9:0] cv_num,
    output logic [7:0] cv_wdata,
    output logic factory_rst,
    output logic [4:0] speed,
    output logic dir_fwd,
    output logic light_key
);
    initial
    begin
        {cv_wr, cv_rd, factory_rst, light_key, speed} = '0;
        cv_num = 10'h3FF;
        cv_wdata = 8'h00;
        dir_fwd = 1'b1;
    end
    // operations-mode write, optionally with a reset command in the same cycle
    task automatic write_cv(input logic [9:0] n, input logic [7:0] d, input logic fr);
        @(posedge clk);
        cv_wr <= 1'b1;
        cv_num <= n;
        cv_wdata <= d;
        factory_rst <= fr;
        @(posedge clk);
        cv_wr <= 1'b0;
        factory_rst <= 1'b0;
        cv_num <= ~n;
        cv_wdata <= ~d;
    endtask : write_cv
    task automatic read_cv(input logic [9:0] n, output logic [7:0] d, output logic ack);
        @(posedge clk);
        cv_rd <= 1'b1;
        cv_num <= n;
        @(posedge clk);
        cv_rd <= 1'b0;
        cv_num <= ~n;
        @(posedge clk);
        ack = rack;
        d = rdata;
    endtask : read_cv
    // key held n edges gives n toggle commands
    task automatic press(input int n);
        @(posedge clk);
        light_key <= 1'b1;
        repeat (n) @(posedge clk);
        light_key <= 1'b0;
    endtask : press
    task automatic drive(input logic [4:0] s, input logic f);
        @(posedge clk);
        speed <= s;
        dir_fwd <= f;
    endtask : drive
endmodule : hmec_station

// File: sim/tb_top.sv
// self-checking testbench for the headlight mode and effect control block
`timescale 1ns/1ps
module tb_top;
    import hmec_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic cv_wr, cv_rd, factory_rst, dir_fwd, light_key, cv_rack, front, rear;
    logic [9:0] cv_num;
    logic [7:0] cv_wdata, cv_rdata, motor_level;
    logic [4:0] speed, sp;
    logic [3:0] ef, er;
    logic fw;
    int n_fail = 0;
    int comparisons = 0;
    int i, k, a, b, c;
    logic [9:0] cvs [7] = '{CV_START, CV_TOP, CV_MID, CV_PERIOD, CV_MODE, CV_FRONT, CV_REAR};
    logic [7:0] facs [7] = '{RST_START, RST_TOP, RST_MID, RST_PERIOD, RST_MODE, RST_FRONT, RST_REAR};
    localparam int TICK = 4;
    always #5 clk_sys = ~clk_sys;
    hmec_top #(.TICK_CYC(TICK)) i_dut (.CLK_SYS(clk_sys), .RSTN(rstn), .CV_WR(cv_wr), .CV_RD(cv_rd),
        .CV_NUM(cv_num), .CV_WDATA(cv_wdata), .FACTORY_RST(factory_rst), .SPEED_STEP(speed),
        .DIR_FWD(dir_fwd), .LIGHT_KEY(light_key), .CV_RDATA(cv_rdata), .CV_RACK(cv_rack),
        .FRONT_LIGHT(front), .REAR_LIGHT(rear), .MOTOR_LEVEL(motor_level));
    hmec_station i_sta (.clk(clk_sys), .rack(cv_rack), .rdata(cv_rdata), .cv_wr(cv_wr), .cv_rd(cv_rd),
        .cv_num(cv_num), .cv_wdata(cv_wdata), .factory_rst(factory_rst), .speed(speed),
        .dir_fwd(dir_fwd), .light_key(light_key));
    // ****************************************
    // expectations and checks
    // ****************************************
    function automatic logic [8:0] exp_duty(input logic [3:0] m, input logic f, input logic [4:0] s,
        input logic [3:0] e, input logic is_front);
        logic on;
        case (m)
            4'h2, 4'h3: on = is_front;
            4'h4, 4'h5: on = !is_front;
            4'h6, 4'h7: on = 1'b1;
            4'h8, 4'h9: on = is_front ^ f;
            default: on = is_front ~^ f;
        endcase
        if (!on) return 9'h000;
        if (m < 4'hA && m[0] && s == 5'h00) return {1'b0, DUTY_AUTO_DIM};
        case (e)
            4'h0: return 9'h000;
            4'h1: return {1'b0, DUTY_6};
            4'h2: return {1'b0, DUTY_25};
            4'h3: return {1'b0, DUTY_50};
            default: return 9'h100;
        endcase
    endfunction : exp_duty
    function automatic logic [7:0] exp_lvl(input int s, input int a, input int b, input int c);
        if (s == 0) return 8'h00;
        if (s >= 28) return 8'(c);
        if (s <= 14) return 8'(a + (b - a) * (s - 1) / 13);
        return 8'(b + (c - b) * (s - 14) / 14);
    endfunction : exp_lvl
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t byte got %h expected %h", $time, got, exp);
        end
    endtask : check_byte
    task automatic check_cnt(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t lit cycles got %0d expected %0d", $time, got, exp);
        end
    endtask : check_cnt
    task automatic rd(input logic [9:0] n, input logic [7:0] exp);
        logic [7:0] d;
        logic ack;
        i_sta.read_cv(n, d, ack);
        check_byte({7'h00, ack}, 8'h01);
        check_byte(d, exp);
    endtask : rd
    // lit cycles over one full 256-cycle pwm period
    task automatic measure(input logic [8:0] exp_f, input logic [8:0] exp_r);
        logic [8:0] cf;
        logic [8:0] cr;
        logic bad;
        cf = '0;
        cr = '0;
        bad = 1'b0;
        repeat (3) @(posedge clk_sys);
        repeat (256)
        begin
            @(posedge clk_sys);
            cf += 9'(front === 1'b1);
            cr += 9'(rear === 1'b1);
            bad |= $isunknown({front, rear});
        end
        // an unknown level fails both counts
        check_cnt(bad ? 9'h1FF : cf, exp_f);
        check_cnt(bad ? 9'h1FF : cr, exp_r);
    endtask : measure
    // lit run of a single-pulse pattern, in cycles
    task automatic measure_run(input logic [8:0] exp);
        logic [8:0] n;
        n = '0;
        repeat (200) @(posedge clk_sys);
        for (int j = 0; j < 1024 && front !== 1'b0; j++) @(posedge clk_sys);
        for (int j = 0; j < 1024 && front !== 1'b1; j++) @(posedge clk_sys);
        while (front === 1'b1 && n < 9'h1FF)
        begin
            @(posedge clk_sys);
            n++;
        end
        check_cnt(n, exp);
    endtask : measure_run
    task automatic cfg(input logic [3:0] m, input logic [3:0] f, input logic [3:0] r, input logic [3:0] p);
        i_sta.write_cv(CV_MODE, {4'h0, m}, 1'b0);
        i_sta.write_cv(CV_FRONT, {4'h0, f}, 1'b0);
        i_sta.write_cv(CV_REAR, {4'h0, r}, 1'b0);
        i_sta.write_cv(CV_PERIOD, {4'h0, p}, 1'b0);
    endtask : cfg
    task automatic summarize();
        if (n_fail == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        void'($urandom(82));
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (i = 0; i < 7; i++) rd(cvs[i], facs[i]);
        rd(10'h03F, 8'h00);
        i_sta.drive(5'h05, 1'b1);
        measure(9'h000, 9'h000);
        i_sta.press(1);
        measure(9'h100, 9'h000);
        i_sta.press(2);
        measure(9'h100, 9'h000);
        for (i = 0; i < 16; i++)
        begin
            for (k = 0; k < 4; k++)
            begin
                sp = k[0] ? 5'($urandom_range(28, 1)) : 5'h00;
                fw = k[1];
                ef = 4'($urandom_range(4));
                er = 4'($urandom_range(4));
                cfg(4'(i), ef, er, 4'($urandom_range(15, 1)));
                i_sta.drive(sp, fw);
                measure(exp_duty(4'(i), fw, sp, ef, 1'b1), exp_duty(4'(i), fw, sp, er, 1'b0));
            end
        end
        cfg(4'h7, 4'hC, 4'hD, 4'h2);
        i_sta.drive(5'h00, 1'b0);
        measure({1'b0, DUTY_AUTO_DIM}, {1'b0, DUTY_AUTO_DIM});
        cfg(4'h7, 4'hC, 4'hD, 4'h1);
        i_sta.drive(5'h05, 1'b1);
        // four pattern rounds fit one pwm window
        measure(9'(256 / PHASE_STEPS), 9'(512 / PHASE_STEPS));
        cfg(4'h7, 4'hC, 4'hD, 4'h3);
        measure_run(9'(3 * TICK));
        i_sta.write_cv(CV_PERIOD, 8'h00, 1'b0);
        rd(CV_PERIOD, PERIOD_MIN);
        i_sta.write_cv(CV_PERIOD, 8'h0F, 1'b0);
        rd(CV_PERIOD, 8'h0F);
        i_sta.write_cv(10'h13C, 8'h05, 1'b0);
        rd(CV_MODE, 8'h07);
        for (i = 0; i < 40; i++)
        begin
            a = $urandom_range(80);
            b = a + $urandom_range(80);
            c = b + $urandom_range(95);
            i_sta.write_cv(CV_START, 8'(a), 1'b0);
            i_sta.write_cv(CV_MID, 8'(b), 1'b0);
            i_sta.write_cv(CV_TOP, 8'(c), 1'b0);
            sp = (i == 0) ? STEP_LOW : (i == 1) ? STEP_MID : (i == 2) ? STEP_TOP : 5'($urandom_range(31));
            i_sta.drive(sp, 1'b1);
            repeat (3) @(posedge clk_sys);
            check_byte(motor_level, exp_lvl(int'(sp), a, b, c));
        end
        i_sta.write_cv(CV_MODE, 8'h07, 1'b1);
        for (i = 0; i < 7; i++) rd(cvs[i], facs[i]);
        measure(9'h100, 9'h000);
        rstn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        measure(9'h000, 9'h000);
        i_sta.press(1);
        measure(9'h100, 9'h000);
        summarize();
    end
    initial
    begin
        #900_000;
        n_fail++;
        summarize();
    end
endmodule : tb_top
